// file: core/pstt_pkg.sv
// Package of constants and state layout for the system time keeper
package pstt_pkg;

    localparam int SEC_W  = 32;
    localparam int FRAC_W = 31;

    // Decimal rollover: one count per nanosecond, 10^9 counts a second
    localparam logic [31:0] DEC_LIMIT = 32'h3B9ACA00;
    // Binary rollover: the whole 31-bit field spans one second
    localparam logic [31:0] BIN_LIMIT = 32'h80000000;

    // Values after reset, and the last seconds count before a wrap
    localparam logic [31:0] RST_SEC  = 32'h00000000;
    localparam logic [30:0] RST_FRAC = 31'h00000000;
    localparam logic [31:0] RST_ACC  = 32'h00000000;
    localparam logic [31:0] SEC_MAX  = 32'hFFFFFFFF;

    typedef struct packed {
        logic [31:0] sec;
        logic [30:0] frac;
        logic [31:0] acc;
        logic [31:0] tgt_sec;
        logic [30:0] tgt_frac;
        logic        armed;
        logic        reached;
        logic        wrapped;
        logic        cause;
        logic        irq;
    } pstt_state_t;

endpackage : pstt_pkg

// file: core/pstt_cmp_if.sv
// Interface carrying the time and target to the comparator
`timescale 1ns/1ps
`default_nettype none
interface pstt_cmp_if;
    logic [31:0] now_sec;
    logic [30:0] now_frac;
    logic [31:0] tgt_sec;
    logic [30:0] tgt_frac;
    logic        at_or_past;

    modport src (output now_sec, now_frac, tgt_sec, tgt_frac,
                 input at_or_past);
    modport cmp (input now_sec, now_frac, tgt_sec, tgt_frac,
                 output at_or_past);
endinterface : pstt_cmp_if
`default_nettype wire

// file: core/pstt_cmp.sv
// Comparator: time at or past the target time
`timescale 1ns/1ps
`default_nettype none
module pstt_cmp (
    pstt_cmp_if.cmp bus
);
    // Seconds first, then fraction, as one wide unsigned number
    assign bus.at_or_past = {bus.now_sec, bus.now_frac}
                            >= {bus.tgt_sec, bus.tgt_frac};
endmodule : pstt_cmp
`default_nettype wire

// file: core/pstt_top.sv
// System time keeper with target time compare
`timescale 1ns/1ps
`default_nettype none
module pstt_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        decimal_rollover_mode,
    input  wire logic        fine_mode,
    input  wire logic [31:0] addend,
    input  wire logic [30:0] sub_increment,
    input  wire logic        load_req,
    input  wire logic        adjust_req,
    input  wire logic        adjust_direction,
    input  wire logic [31:0] req_seconds,
    input  wire logic [30:0] req_fraction,
    input  wire logic        target_write,
    input  wire logic [31:0] target_seconds,
    input  wire logic [30:0] target_fraction,
    input  wire logic        target_int_enable,
    input  wire logic        target_ack,
    input  wire logic        wrap_ack,
    output logic      [31:0] whole_second_count,
    output logic      [30:0] fraction_count,
    output logic             target_reached_flag,
    output logic             seconds_wrap_flag,
    output logic             time_event_cause,
    output logic             eth_irq
);

    pstt_pkg::pstt_state_t st;
    pstt_pkg::pstt_state_t next_st;

    pstt_cmp_if cmp_bus ();

    logic [31:0] limit;
    logic [32:0] acc_sum;
    logic        tick;
    logic [31:0] frac_sum;
    logic        carry;
    logic [31:0] tick_frac;
    logic [31:0] tick_sec;
    logic [31:0] adj_frac;
    logic [31:0] adj_sec;
    logic        fire;

    // Rollover point selects the weight of a fraction count
    assign limit = decimal_rollover_mode ? pstt_pkg::DEC_LIMIT
                                         : pstt_pkg::BIN_LIMIT;

    // Fine mode ticks on accumulator overflow, coarse on every clock
    assign acc_sum = {1'b0, st.acc} + {1'b0, addend};
    assign tick    = fine_mode ? acc_sum[32] : 1'b1;

    // Each tick adds the increment, carrying into seconds at rollover
    always_comb begin
        frac_sum  = {1'b0, st.frac} + {1'b0, sub_increment};
        carry     = frac_sum >= limit;
        tick_frac = carry ? frac_sum - limit : frac_sum;
        tick_sec  = st.sec + {31'h00000000, carry};
    end

    // Adjust with borrow or carry across the fraction boundary
    always_comb begin
        adj_frac = {1'b0, st.frac};
        adj_sec  = st.sec;
        if (adjust_direction) begin
            adj_frac = {1'b0, st.frac} + {1'b0, req_fraction};
            adj_sec  = st.sec + req_seconds;
            if (adj_frac >= limit) begin
                adj_frac = adj_frac - limit;
                adj_sec  = adj_sec + 32'h00000001;
            end
        end else begin
            adj_sec = st.sec - req_seconds;
            if (st.frac >= req_fraction) begin
                adj_frac = {1'b0, st.frac} - {1'b0, req_fraction};
            end else begin
                adj_frac = {1'b0, st.frac} + limit - {1'b0, req_fraction};
                adj_sec  = adj_sec - 32'h00000001;
            end
        end
    end

    // Comparator looks at the time as it will stand after this tick
    assign cmp_bus.now_sec  = tick_sec;
    assign cmp_bus.now_frac = tick_frac[30:0];
    assign cmp_bus.tgt_sec  = st.tgt_sec;
    assign cmp_bus.tgt_frac = st.tgt_frac;

    pstt_cmp u_cmp (
        .bus (cmp_bus)
    );

    // Only a plain tick may fire; loads and adjusts never do
    assign fire = tick && !load_req && !adjust_req && st.armed
                  && target_int_enable && cmp_bus.at_or_past;

    // Next state: load beats adjust beats tick
    always_comb begin
        next_st     = st;
        next_st.acc = acc_sum[31:0];
        if (load_req) begin
            next_st.sec  = req_seconds;
            next_st.frac = req_fraction;
        end else if (adjust_req) begin
            next_st.sec  = adj_sec;
            next_st.frac = adj_frac[30:0];
        end else if (tick) begin
            next_st.sec  = tick_sec;
            next_st.frac = tick_frac[30:0];
        end
        // A target write arms one shot; a low enable without a write disarms it
        if (target_write) begin
            next_st.tgt_sec  = target_seconds;
            next_st.tgt_frac = target_fraction;
            next_st.armed    = 1'b1;
        end else if (!target_int_enable || fire) begin
            next_st.armed = 1'b0;
        end
        // Sticky status; a set in the clearing cycle wins
        if (target_ack) begin
            next_st.reached = 1'b0;
            next_st.cause   = 1'b0;
        end
        if (fire) begin
            next_st.reached = 1'b1;
            next_st.cause   = 1'b1;
        end
        if (wrap_ack) begin
            next_st.wrapped = 1'b0;
        end
        if (!load_req && !adjust_req && tick && carry
            && st.sec == pstt_pkg::SEC_MAX) begin
            next_st.wrapped = 1'b1;
        end
        next_st.irq = next_st.cause;
    end

    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st          <= '0;
            st.sec      <= pstt_pkg::RST_SEC;
            st.frac     <= pstt_pkg::RST_FRAC;
            st.acc      <= pstt_pkg::RST_ACC;
            st.tgt_sec  <= pstt_pkg::RST_SEC;
            st.tgt_frac <= pstt_pkg::RST_FRAC;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flip-flops
    assign whole_second_count  = st.sec;
    assign fraction_count      = st.frac;
    assign target_reached_flag = st.reached;
    assign seconds_wrap_flag   = st.wrapped;
    assign time_event_cause    = st.cause;
    assign eth_irq             = st.irq;

    // Load takes effect on the next edge
    property p_load;
        @(posedge mclk) disable iff (rst)
        load_req |=> whole_second_count == $past(req_seconds)
                     && fraction_count == $past(req_fraction);
    endproperty
    a_load: assert property (p_load)
        else $error("load did not replace the time");

    // Advance by whole seconds leaves the fraction alone
    property p_adj_up;
        @(posedge mclk) disable iff (rst)
        adjust_req && !load_req && adjust_direction
            && req_fraction == 31'h00000000
        |=> whole_second_count == $past(whole_second_count)
                + $past(req_seconds)
            && $stable(fraction_count);
    endproperty
    a_adj_up: assert property (p_adj_up)
        else $error("forward adjust wrong");

    // Retard by whole seconds
    property p_adj_down;
        @(posedge mclk) disable iff (rst)
        adjust_req && !load_req && !adjust_direction
            && req_fraction == 31'h00000000
        |=> whole_second_count == $past(whole_second_count)
                - $past(req_seconds);
    endproperty
    a_adj_down: assert property (p_adj_down)
        else $error("backward adjust wrong");

    // Decimal fraction never reaches a full second after a tick
    property p_dec_range;
        @(posedge mclk) disable iff (rst)
        decimal_rollover_mode && !load_req && !adjust_req
            && {1'b0, fraction_count} < pstt_pkg::DEC_LIMIT
            && {1'b0, sub_increment} < pstt_pkg::DEC_LIMIT
        |=> {1'b0, fraction_count} < pstt_pkg::DEC_LIMIT;
    endproperty
    a_dec_range: assert property (p_dec_range)
        else $error("decimal fraction out of range");

    // Coarse mode moves the time every clock
    property p_coarse;
        @(posedge mclk) disable iff (rst)
        !fine_mode && !load_req && !adjust_req
            && sub_increment != 31'h00000000
        |=> !($stable(fraction_count) && $stable(whole_second_count));
    endproperty
    a_coarse: assert property (p_coarse)
        else $error("coarse tick missing");

    // Target status rises only with time at or past the target
    property p_fire_ge;
        @(posedge mclk) disable iff (rst)
        $rose(target_reached_flag)
        |-> {whole_second_count, fraction_count}
            >= {st.tgt_sec, st.tgt_frac};
    endproperty
    a_fire_ge: assert property (p_fire_ge)
        else $error("target fired early");

    // Interrupt and cause bit go with the target status
    property p_irq;
        @(posedge mclk) disable iff (rst)
        $rose(target_reached_flag) |-> time_event_cause ##0 eth_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised with target");

    // No target event while the enable is low
    property p_disabled;
        @(posedge mclk) disable iff (rst)
        !target_int_enable |=> !$rose(target_reached_flag);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("target fired while disabled");

    // Target status sticks until acknowledged
    property p_sticky;
        @(posedge mclk) disable iff (rst)
        target_reached_flag && !target_ack |=> target_reached_flag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("target status dropped without ack");

    // Seconds wrap lands on zero
    property p_wrap;
        @(posedge mclk) disable iff (rst)
        $rose(seconds_wrap_flag) |-> whole_second_count == 32'h00000000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap status without seconds wrap");

endmodule : pstt_top
`default_nettype wire

// file: tb/pstt_top_tb.sv
// Self-checking bench for the system time keeper with target compare
`timescale 1ns/1ps
`default_nettype none
module pstt_top_tb;
    logic        mclk, rst, dec, fine, load, adj, dir, tw, en, tack, wack;
    logic [31:0] addend, rsec, tsec, lim, m_sec, m_acc, m_ts, seed, r, l;
    logic [30:0] inc, rfrac, tfrac, m_frac, m_tf, i;
    logic        m_armed, m_reach, m_wrap;
    logic [63:0] n;
    logic [31:0] whole_second_count;
    logic [30:0] fraction_count;
    logic        target_reached_flag, seconds_wrap_flag;
    logic        time_event_cause, eth_irq;
    int          num_errors, num_checks, t;

    pstt_top pstt_top_i (
        .mclk(mclk), .rst(rst), .decimal_rollover_mode(dec),
        .fine_mode(fine), .addend(addend), .sub_increment(inc),
        .load_req(load), .adjust_req(adj), .adjust_direction(dir),
        .req_seconds(rsec), .req_fraction(rfrac), .target_write(tw),
        .target_seconds(tsec), .target_fraction(tfrac),
        .target_int_enable(en), .target_ack(tack), .wrap_ack(wack),
        .whole_second_count(whole_second_count),
        .fraction_count(fraction_count),
        .target_reached_flag(target_reached_flag),
        .seconds_wrap_flag(seconds_wrap_flag),
        .time_event_cause(time_event_cause), .eth_irq(eth_irq)
    );

    // Step a time by an interval, carry or borrow at the rollover limit
    function automatic logic [63:0] step_t(input logic [31:0] s, f, ds, df,
                                           input logic [31:0] lm,
                                           input logic up);
        logic [32:0] x;
        x = f + df;
        if (up && x >= lm) return {s + ds + 32'h1, x[31:0] - lm};
        if (up) return {s + ds, x[31:0]};
        if (f < df) return {s - ds - 32'h1, f + lm - df};
        return {s - ds, f - df};
    endfunction

    // Reference time keeper; load beats adjust beats tick
    always @(posedge mclk or posedge rst) begin : ref_model
        logic [32:0] a;
        logic [63:0] nx;
        if (rst) begin
            {m_sec, m_frac, m_acc, m_ts, m_tf} <= '0;
            {m_armed, m_reach, m_wrap} <= 3'h0;
        end else begin
            a = m_acc + addend;
            m_acc <= a[31:0];
            nx = {m_sec, 1'b0, m_frac};
            m_armed <= m_armed & en;
            // Acks first so that a same-edge set wins
            if (tack) m_reach <= 1'b0;
            if (wack) m_wrap <= 1'b0;
            if (load) nx = {rsec, 1'b0, rfrac};
            else if (adj) nx = step_t(m_sec, {1'b0, m_frac}, rsec,
                                      {1'b0, rfrac}, lim, dir);
            else if (!fine || a[32]) begin
                nx = step_t(m_sec, {1'b0, m_frac}, 32'h0, {1'b0, inc},
                            lim, 1'b1);
                if (nx[63:32] < m_sec) m_wrap <= 1'b1;
                if (m_armed && en && {nx[63:32], nx[30:0]} >= {m_ts, m_tf})
                begin
                    m_reach <= 1'b1;
                    m_armed <= 1'b0;
                end
            end
            if (tw) begin
                m_armed <= 1'b1;
                {m_ts, m_tf} <= {tsec, tfrac};
            end
            m_sec <= nx[63:32];
            m_frac <= nx[30:0];
        end
    end

    task check(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task end_of_test;
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Outputs compared mid-cycle, well away from the launching edge
    always @(negedge mclk) begin
        if (!rst) begin
            check("seconds", whole_second_count, m_sec);
            check("fraction", fraction_count, m_frac);
            check("reached", target_reached_flag, m_reach);
            check("cause", time_event_cause, m_reach);
            check("irq", eth_irq, m_reach);
            check("wrap", seconds_wrap_flag, m_wrap);
        end
    end

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Hang guard; the run needs well under a thousand cycles
    initial begin
        #1000000;
        num_errors++;
        end_of_test;
    end

    initial begin
        seed = 32'h2D06E0FE;
        {rst, dec, fine, load, adj, dir, tw, en, tack, wack} = 10'h200;
        {addend, rsec, tsec} = '0;
        {inc, rfrac, tfrac} = '0;
        lim = pstt_pkg::BIN_LIMIT;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (t = 0; t < 6; t++) begin
            // A second reset in mid-run
            if (t == 3) begin
                rst <= 1'b1;
                @(posedge mclk);
                rst <= 1'b0;
            end
            @(posedge mclk);
            l = t[0] ? pstt_pkg::DEC_LIMIT : pstt_pkg::BIN_LIMIT;
            r = $random(seed);
            i = {11'h000, r[19:0]} + 31'h1;
            dec <= t[0];
            fine <= t[1];
            lim <= l;
            inc <= i;
            addend <= $random(seed) | 32'h80000000;
            // Load just below the seconds wrap; also legalises the fraction
            load <= 1'b1;
            rsec <= 32'hFFFFFFFF;
            rfrac <= 31'(l - {1'b0, i} * 32'h3);
            @(posedge mclk);
            load <= 1'b0;
            repeat (8) @(posedge mclk);
            // Random loads, adjusts both ways and acks
            repeat (40) begin
                @(posedge mclk);
                r = $random(seed);
                load <= (r[3:0] == 4'h0);
                adj <= (r[6:4] == 3'h0);
                dir <= r[7];
                wack <= (r[11:8] == 4'h0);
                tack <= (r[15:12] == 4'h0);
                rsec <= $random(seed);
                r = $random(seed);
                rfrac <= 31'(r % l);
            end
            @(posedge mclk);
            {load, adj, tack, wack} <= 4'h0;
            @(posedge mclk);
            n = step_t(m_sec, {1'b0, m_frac}, 32'h0, {1'b0, i} * 32'h18,
                       l, 1'b1);
            tw <= 1'b1;
            en <= 1'b1;
            tsec <= n[63:32];
            tfrac <= n[30:0];
            @(posedge mclk);
            tw <= 1'b0;
            // Dropping enable must cancel; raising it again must not refire
            if (t == 2 || t == 5) begin
                repeat (3) @(posedge mclk);
                en <= 1'b0;
                @(posedge mclk);
                en <= 1'b1;
            end
            repeat (60) @(posedge mclk);
            tack <= 1'b1;
            @(posedge mclk);
            tack <= 1'b0;
            repeat (4) @(posedge mclk);
            $display("test %0d done, mismatches so far %0d", t, num_errors);
        end
        end_of_test;
    end
endmodule // pstt_top_tb
`default_nettype wire
